//--- include/ufeb_pkg.sv
// Constants and types for the UART flow, error and break block
package ufeb_pkg;
  // Register offsets
  localparam logic [11:0] OFS_RESUME = 12'h007;
  localparam logic [11:0] OFS_PAUSE = 12'h008;
  localparam logic [11:0] OFS_ERROR = 12'h009;
  localparam logic [11:0] OFS_BREAK = 12'h00a;
  // Values after reset
  localparam logic [7:0] RST_RESUME = 8'h11;
  localparam logic [7:0] RST_PAUSE = 8'h13;
  localparam logic [15:0] RST_BREAK = 16'h0000;
  // Error register bit positions
  localparam int BIT_BRK_LIVE = 7;
  localparam int BIT_OVERRUN = 6;
  localparam int BIT_PARITY = 5;
  localparam int BIT_FRAMING = 4;
  localparam int BIT_BRK_SEEN = 3;
  // Flow-control mode field codes
  localparam logic [2:0] MODE_SW_FLOW = 3'h2;
  localparam logic [2:0] MODE_DROP_RX = 3'h3;
  localparam logic [2:0] MODE_DROP_RXTX = 3'h4;
  // Break control values
  localparam logic [15:0] BRK_STOP = 16'h0000;
  localparam logic [15:0] BRK_FOREVER = 16'hffff;
  // Break timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_TIME_NS = 1000000;
  localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
  // Wide-mode error tag layout
  localparam int TAG_PARITY = 0;
  localparam int TAG_FRAMING = 1;
  localparam int TAG_BREAK = 2;
  typedef enum logic [2:0] {
    BRK_IDLE = 3'h1,
    BRK_WAIT_TX = 3'h2,
    BRK_SEND = 3'h4
  } ufeb_brk_state_t;
endpackage

//--- include/ufeb_brk_if.sv
// Carrier between register logic and break generator
`timescale 1ns/100ps
interface ufeb_brk_if;
  logic wr;
  logic [15:0] wdata;
  logic tx_busy;
  logic [15:0] count;
  logic active;
  modport ctl(output wr, output wdata, output tx_busy,
              input count, input active);
  modport gen(input wr, input wdata, input tx_busy,
              output count, output active);
endinterface

//--- hw/ufeb_break_gen.sv
// Millisecond-timed transmit break generator
`timescale 1ns/100ps
module ufeb_break_gen #(
  parameter int MS_CYC = ufeb_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Control from register logic
  ufeb_brk_if.gen brk
);
  import ufeb_pkg::*;
  localparam int PW = $clog2(MS_CYC + 1);
  localparam logic [PW-1:0] PS_LAST = PW'(MS_CYC - 1);

  ufeb_brk_state_t state;
  logic [PW-1:0] prescale;
  logic ms_tick;

  // Timer only runs while the break is on the line, so N ms is exact
  assign ms_tick = (state == BRK_SEND) && (prescale == PS_LAST);
  assign brk.active = (state == BRK_SEND);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prescale <= '0;
    end else if (brk.wr || state != BRK_SEND || ms_tick) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + PW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      brk.count <= RST_BREAK;
    end else if (brk.wr) begin
      brk.count <= brk.wdata;
    end else if (ms_tick && brk.count != BRK_FOREVER &&
                 brk.count != BRK_STOP) begin
      brk.count <= brk.count - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= BRK_IDLE;
    end else if (brk.wr) begin
      // Rewrite during a break keeps the line low, no glitch high
      if (brk.wdata == BRK_STOP) begin
        state <= BRK_IDLE;
      end else if (state != BRK_SEND) begin
        state <= BRK_WAIT_TX;
      end
    end else begin
      case (state)
        BRK_IDLE: state <= BRK_IDLE;
        BRK_WAIT_TX: begin
          if (!brk.tx_busy) begin
            state <= BRK_SEND;
          end
        end
        BRK_SEND: begin
          if (brk.count == BRK_STOP) begin
            state <= BRK_IDLE;
          end
        end
        default: state <= BRK_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_forever_holds: assert property (
    brk.active && brk.count == BRK_FOREVER && !brk.wr
    |=> brk.active && brk.count == BRK_FOREVER)
    else $error("continuous break did not hold");
  a_ms_countdown: assert property (
    ms_tick && !brk.wr && brk.count != BRK_FOREVER
    && brk.count != BRK_STOP
    |=> brk.count == $past(brk.count) - 16'h0001)
    else $error("break counter did not step down");
  a_zero_stops: assert property (
    brk.wr && brk.wdata == BRK_STOP |=> !brk.active)
    else $error("break not stopped by zero write");
  a_write_loads: assert property (
    brk.wr |=> brk.count == $past(brk.wdata))
    else $error("break write not applied");
  a_wait_busy: assert property (
    state == BRK_WAIT_TX && brk.tx_busy && !brk.wr |=> !brk.active)
    else $error("break began during a character");
  a_start_soon: assert property (
    brk.wr && brk.wdata != BRK_STOP && !brk.tx_busy ##1
    (!brk.tx_busy && !brk.wr) |=> brk.active)
    else $error("break start late");
  a_release_zero: assert property (
    brk.active && brk.count == BRK_STOP && !brk.wr |=> !brk.active)
    else $error("break not released at zero");
  c_timed_break: cover property (ms_tick && brk.count == 16'h0001);
  c_abort: cover property (brk.active && brk.wr);
endmodule

//--- hw/ufeb_top.sv
// Flow characters, error status and transmit break for the UART
// Summary of operation
// - Resume character restarts transmit in software flow
// - Pause character halts transmit in software flow
// - Compare low eight bits, ninth bit zero
// - Multidrop: resume register is unicast address
// - Multidrop: pause register is multicast address
// - Error register accumulates, read clears sticky flags
// - Bit 7 shows live receive break
// - Bit 6 overrun when FIFO full
// - Bit 5 parity error, clear on read
// - Bit 4 framing error, clear on read
// - Bit 3 sticky break until read
// - Wide mode tags errors per byte
// - All ones gives continuous break
// - Value N gives N ms break countdown
// - Zero ends any break
// - Any break write restarts with new value
// - Finish current character before break
// - Break starts within one millisecond
// - Release within two characters after zero
// - Software flow active in mode 010
`timescale 1ns/100ps
module ufeb_top #(
  parameter int MS_CYC = ufeb_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Line configuration
  input wire logic [2:0] flow_mode,
  input wire logic wide_mode,
  // Receiver events
  input wire logic rx_valid,
  input wire logic [8:0] rx_char,
  input wire logic rx_parity_err,
  input wire logic rx_frame_err,
  input wire logic rx_fifo_full,
  input wire logic rx_break_live,
  // Transmitter
  input wire logic tx_busy,
  input wire logic tx_serial,
  output logic tx_pin,
  output logic tx_halt,
  // Address match
  output logic uni_match,
  output logic multi_match,
  // Wide-mode receive stream
  output logic rx_out_valid,
  output logic [8:0] rx_out_char,
  output logic [2:0] rx_out_err
);
  import ufeb_pkg::*;

  logic [7:0] resume_char;
  logic [7:0] pause_char;
  logic err_overrun;
  logic err_parity;
  logic err_framing;
  logic err_break;
  logic sw_flow;
  logic drop_mode;
  logic err_read;
  logic hit_resume;
  logic hit_pause;
  logic ev_overrun;
  logic [15:0] err_word;
  logic [15:0] next_rdata;

  ufeb_brk_if brk ();

  // Data character matches only with ninth bit clear
  function automatic logic f_data_hit(input logic [8:0] ch,
                                      input logic [7:0] ref_ch);
    f_data_hit = !ch[8] && (ch[7:0] == ref_ch);
  endfunction

  function automatic logic f_addr_hit(input logic [8:0] ch,
                                      input logic [7:0] ref_ch);
    f_addr_hit = ch[8] && (ch[7:0] == ref_ch);
  endfunction

  function automatic logic f_sel(input logic [11:0] a,
                                 input logic [11:0] ofs);
    f_sel = (a == ofs);
  endfunction

  assign sw_flow = (flow_mode == MODE_SW_FLOW);
  assign drop_mode = (flow_mode == MODE_DROP_RX) ||
                     (flow_mode == MODE_DROP_RXTX);
  assign err_read = reg_rd && f_sel(reg_addr, OFS_ERROR);
  assign hit_resume = rx_valid && f_data_hit(rx_char, resume_char);
  assign hit_pause = rx_valid && f_data_hit(rx_char, pause_char);
  assign ev_overrun = rx_valid && rx_fifo_full;

  assign brk.wr = reg_wr && f_sel(reg_addr, OFS_BREAK);
  assign brk.wdata = reg_wdata;
  assign brk.tx_busy = tx_busy;

  ufeb_break_gen #(
    .MS_CYC(MS_CYC)
  ) u_break (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .brk(brk.gen)
  );

  // Character registers, only the low byte is stored
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      resume_char <= RST_RESUME;
      pause_char <= RST_PAUSE;
    end else if (reg_wr) begin
      if (f_sel(reg_addr, OFS_RESUME)) begin
        resume_char <= reg_wdata[7:0];
      end
      if (f_sel(reg_addr, OFS_PAUSE)) begin
        pause_char <= reg_wdata[7:0];
      end
    end
  end

  // Sticky error flags: an event in the read cycle survives the clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      err_overrun <= 1'b0;
      err_parity <= 1'b0;
      err_framing <= 1'b0;
      err_break <= 1'b0;
    end else begin
      err_overrun <= ev_overrun ||
                     (err_overrun && !err_read);
      err_parity <= (rx_valid && rx_parity_err) ||
                    (err_parity && !err_read);
      err_framing <= (rx_valid && rx_frame_err) ||
                     (err_framing && !err_read);
      err_break <= rx_break_live ||
                   (err_break && !err_read);
    end
  end

  always_comb begin
    err_word = 16'h0000;
    err_word[BIT_BRK_LIVE] = rx_break_live;
    err_word[BIT_OVERRUN] = err_overrun;
    err_word[BIT_PARITY] = err_parity;
    err_word[BIT_FRAMING] = err_framing;
    err_word[BIT_BRK_SEEN] = err_break;
  end

  always_comb begin
    next_rdata = 16'h0000;
    case (reg_addr)
      OFS_RESUME: next_rdata = {8'h00, resume_char};
      OFS_PAUSE: next_rdata = {8'h00, pause_char};
      OFS_ERROR: next_rdata = err_word;
      OFS_BREAK: next_rdata = brk.count;
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data held until the next read
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Pause wins if both characters are equal
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_halt <= 1'b0;
    end else if (!sw_flow) begin
      tx_halt <= 1'b0;
    end else if (hit_pause) begin
      tx_halt <= 1'b1;
    end else if (hit_resume) begin
      tx_halt <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      uni_match <= 1'b0;
      multi_match <= 1'b0;
    end else begin
      uni_match <= drop_mode && rx_valid &&
                   f_addr_hit(rx_char, resume_char);
      multi_match <= drop_mode && rx_valid &&
                     f_addr_hit(rx_char, pause_char);
    end
  end

  // Tags are zero outside wide mode so downstream can ignore them
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_out_valid <= 1'b0;
      rx_out_char <= 9'h000;
      rx_out_err <= 3'h0;
    end else begin
      rx_out_valid <= rx_valid;
      if (rx_valid) begin
        rx_out_char <= rx_char;
        rx_out_err <= 3'h0;
        if (wide_mode) begin
          rx_out_err[TAG_PARITY] <= rx_parity_err;
          rx_out_err[TAG_FRAMING] <= rx_frame_err;
          rx_out_err[TAG_BREAK] <= rx_break_live;
        end
      end
    end
  end

  // Idle-high line forced low during break
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_pin <= 1'b1;
    end else begin
      tx_pin <= tx_serial && !brk.active;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_resume_restart: assert property (
    sw_flow && hit_resume && !hit_pause ##1 sw_flow |-> !tx_halt)
    else $error("resume character did not restart transmit");
  a_pause_halt: assert property (
    sw_flow && hit_pause ##1 sw_flow |-> tx_halt)
    else $error("pause character did not halt transmit");
  a_ninth_bit: assert property (
    sw_flow && !tx_halt && rx_valid && rx_char[8] ##1 sw_flow
    |-> !tx_halt)
    else $error("nine-bit character matched flow character");
  a_unicast_hit: assert property (
    drop_mode && rx_valid && rx_char == {1'b1, resume_char}
    |=> uni_match)
    else $error("unicast address missed");
  a_multicast_hit: assert property (
    drop_mode && rx_valid && rx_char == {1'b1, pause_char}
    |=> multi_match)
    else $error("multicast address missed");
  a_read_clears: assert property (
    err_read && !rx_valid && !rx_break_live
    |=> err_word[6:3] == 4'h0)
    else $error("error read did not clear flags");
  a_live_break: assert property (
    err_read |=> reg_rdata[BIT_BRK_LIVE] == $past(rx_break_live))
    else $error("live break bit wrong");
  a_overrun_set: assert property (
    ev_overrun ##1 !err_read ##1 err_read |=> reg_rdata[BIT_OVERRUN])
    else $error("overrun not reported");
  a_parity_set: assert property (
    rx_valid && rx_parity_err && err_read
    |=> err_parity)
    else $error("parity event lost on read");
  a_framing_set: assert property (
    rx_valid && rx_frame_err |=> err_framing)
    else $error("framing error not flagged");
  a_break_sticky: assert property (
    rx_break_live ##1 !rx_break_live && !err_read |=> err_break)
    else $error("break history lost");
  a_wide_tag: assert property (
    rx_valid && wide_mode |=> rx_out_err ==
    {$past(rx_break_live), $past(rx_frame_err), $past(rx_parity_err)})
    else $error("wide-mode tag wrong");
  a_tx_forced: assert property (
    brk.active |=> !tx_pin)
    else $error("break not on transmit pin");
  a_reserved_zero: assert property (
    reg_rd && reg_addr != OFS_BREAK |=> reg_rdata[15:8] == 8'h00)
    else $error("reserved bits not zero");
  a_halt_mode_off: assert property (
    !sw_flow |=> !tx_halt)
    else $error("transmit halted outside software flow");
  a_addr_mode: assert property (
    !drop_mode |=> !uni_match && !multi_match)
    else $error("address match outside multidrop");
  a_data_no_addr: assert property (
    drop_mode && rx_valid && !rx_char[8] |=> !uni_match)
    else $error("data character matched as address");
  a_tag_off: assert property (
    rx_valid && !wide_mode |=> rx_out_err == 3'h0)
    else $error("error tag outside wide mode");
  a_err_low_zero: assert property (
    reg_rd && reg_addr == OFS_ERROR |=> reg_rdata[2:0] == 3'h0)
    else $error("low error bits not zero");
  a_overrun_clear: assert property (
    err_read && !rx_valid |=> !err_overrun)
    else $error("overrun flag not cleared by read");
  a_parity_clear: assert property (
    err_read && !rx_valid |=> !err_parity)
    else $error("parity flag not cleared by read");
  a_frame_clear: assert property (
    err_read && !rx_valid |=> !err_framing)
    else $error("framing flag not cleared by read");
  a_brk_seen_rd: assert property (
    err_read |=> reg_rdata[BIT_BRK_SEEN] == $past(err_break))
    else $error("break history bit wrong");
  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_resume_write: assert property (
    reg_wr && reg_addr == OFS_RESUME |=> resume_char == $past(reg_wdata[7:0]))
    else $error("resume character write lost");
  c_sw_pause: cover property (sw_flow && hit_pause ##[1:20] hit_resume);
  c_err_read: cover property (err_read && err_word[6:3] != 4'h0);
  c_uni: cover property (uni_match);
endmodule

//--- testbench/ufeb_node.sv
// Remote serial node model: received characters and line breaks
`timescale 1ns/100ps
module ufeb_node (
  // Clock
  input wire logic clk_sys,
  // Receive events towards the block
  output logic rx_valid,
  output logic [8:0] rx_char,
  output logic rx_parity_err,
  output logic rx_frame_err,
  output logic rx_fifo_full,
  output logic rx_break_live
);
  initial begin
    rx_valid = 1'b0;
    rx_char = 9'h1a5;
    {rx_fifo_full, rx_frame_err, rx_parity_err} = 3'b010;
    rx_break_live = 1'b0;
  end

  // One character; err is {overrun, framing, parity}
  task automatic send(input logic [8:0] ch, input logic [2:0] err);
    @(negedge clk_sys);
    rx_valid = 1'b1;
    rx_char = ch;
    {rx_fifo_full, rx_frame_err, rx_parity_err} = err;
    @(negedge clk_sys);
    rx_valid = 1'b0;
    // Qualifiers are not held once the strobe is gone
    rx_char = ~ch;
    {rx_fifo_full, rx_frame_err, rx_parity_err} = ~err;
  endtask

  task automatic set_break(input logic v);
    @(negedge clk_sys);
    rx_break_live = v;
  endtask
endmodule

//--- testbench/ufeb_top_tb.sv
// Self-checking bench for the flow, error and break block
`timescale 1ns/100ps
module ufeb_top_tb;
  import ufeb_pkg::*;
  // Short millisecond keeps break runs brief
  localparam int MS = 20;
  logic clk_sys, reset_n, reg_wr, reg_rd, wide_mode, tx_busy, tx_serial;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0] flow_mode, rx_out_err;
  logic rx_valid, rx_parity_err, rx_frame_err, rx_fifo_full, rx_break_live;
  logic [8:0] rx_char, rx_out_char;
  logic tx_pin, tx_halt, uni_match, multi_match, rx_out_valid, rd_d;
  logic [15:0] expq[$];
  logic [7:0] res, pau;
  int n_errors, n_compared, n, w;

  ufeb_top #(.MS_CYC(MS)) uut (.clk_sys, .reset_n, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .flow_mode, .wide_mode, .rx_valid,
    .rx_char, .rx_parity_err, .rx_frame_err, .rx_fifo_full, .rx_break_live,
    .tx_busy, .tx_serial, .tx_pin, .tx_halt, .uni_match, .multi_match,
    .rx_out_valid, .rx_out_char, .rx_out_err);

  ufeb_node node (.clk_sys, .rx_valid, .rx_char, .rx_parity_err,
    .rx_frame_err, .rx_fifo_full, .rx_break_live);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  // Expected read value is queued for the monitor
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    expq.push_back(exp);
    @(negedge clk_sys);
    reg_rd = 1'b0;
  endtask

  // Wait for the break to start, then measure how long it stays low
  task automatic low_len(output int wt, output int len);
    wt = 0;
    len = 0;
    while (tx_pin !== 1'b0 && wt < 60) begin
      @(negedge clk_sys);
      wt++;
    end
    while (tx_pin === 1'b0 && len < 5000) begin
      @(negedge clk_sys);
      len++;
    end
  endtask

  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_d === 1'b1) begin
      check(reg_rdata, expq.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end

  initial begin
    reset_n = 1'b0;
    {reg_wr, reg_rd, wide_mode, tx_busy} = 4'h0;
    tx_serial = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 16'h0000;
    flow_mode = 3'h0;
    n_errors = 0;
    n_compared = 0;
    void'($urandom(73895));
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    rd(OFS_RESUME, {8'h00, RST_RESUME});
    rd(OFS_PAUSE, {8'h00, RST_PAUSE});
    rd(OFS_ERROR, 16'h0000);
    rd(OFS_BREAK, RST_BREAK);
    rd(12'h00b, 16'h0000);
    res = 8'h20 + 8'($urandom_range(63));
    pau = res ^ 8'h80;
    wr(OFS_RESUME, {8'($urandom), res});
    wr(OFS_PAUSE, {8'hff, pau});
    wr(OFS_ERROR, 16'hffff);
    rd(OFS_RESUME, {8'h00, res});
    rd(OFS_PAUSE, {8'h00, pau});
    rd(OFS_ERROR, 16'h0000);
    for (int m = 0; m < 5; m++) begin
      // Mode only changes with no character in flight
      flow_mode = 3'(m);
      node.send({1'b0, pau}, 3'b000);
      check(tx_halt, m == 2);
      node.send({1'b1, res}, 3'b000);
      check(tx_halt, m == 2);
      check(uni_match, m > 2);
      node.send({1'b1, pau}, 3'b000);
      check(multi_match, m > 2);
      node.send({1'b0, res}, 3'b000);
      check(tx_halt, 1'b0);
      node.send({1'b1, pau}, 3'b000);
      check(tx_halt, 1'b0);
    end
    flow_mode = 3'h0;
    wide_mode = 1'b1;
    node.send(9'h041, 3'b011);
    check(rx_out_err, 3'b011);
    check(rx_out_char, 9'h041);
    check(rx_out_valid, 1'b1);
    wide_mode = 1'b0;
    node.send(9'h042, 3'b001);
    check(rx_out_err, 3'b000);
    rd(OFS_ERROR, 16'h0030);
    check(rx_out_valid, 1'b0);
    node.send(9'h043, 3'b100);
    rd(OFS_ERROR, 16'h0040);
    rd(OFS_ERROR, 16'h0000);
    node.set_break(1'b1);
    repeat (3) @(negedge clk_sys);
    rd(OFS_ERROR, 16'h0088);
    node.set_break(1'b0);
    rd(OFS_ERROR, 16'h0008);
    rd(OFS_ERROR, 16'h0000);
    // Character in flight must finish before the break
    tx_busy = 1'b1;
    wr(OFS_BREAK, 16'd2);
    repeat (30) @(negedge clk_sys);
    check(tx_pin, 1'b1);
    tx_busy = 1'b0;
    low_len(w, n);
    check(w <= MS, 1'b1);
    check(n >= 2 * MS && n <= 2 * MS + 3, 1'b1);
    rd(OFS_BREAK, 16'h0000);
    wr(OFS_BREAK, BRK_FOREVER);
    repeat (8 * MS) @(negedge clk_sys);
    check(tx_pin, 1'b0);
    rd(OFS_BREAK, BRK_FOREVER);
    wr(OFS_BREAK, 16'd1);
    @(negedge clk_sys);
    check(tx_pin, 1'b0);
    repeat (10) @(negedge clk_sys);
    check(tx_pin, 1'b0);
    low_len(w, n);
    check(n < 2 * MS, 1'b1);
    wr(OFS_BREAK, BRK_FOREVER);
    repeat (10) @(negedge clk_sys);
    wr(OFS_BREAK, BRK_STOP);
    repeat (3) @(negedge clk_sys);
    check(tx_pin, 1'b1);
    // With no break the line follows the shifter
    tx_serial = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(tx_pin, 1'b0);
    tx_serial = 1'b1;
    repeat (3) @(negedge clk_sys);
    close_out();
  end
endmodule
